// >>> rtl/dbg_abs_pkg.sv
// constants, layouts and carrier types for the abstract command block
// Notes on behaviour
// - regs 0-0xFFF csr, next 32 gpr, rest unimplemented
// - illegal regno with transfer set: error three
// - virtual flag bit 23 reads zero, no error
// - size 0/1/2 selects 8/16/32 bits, resets 2
// - small size to instruction memory/pic: error three
// - memory size above two: error two
// - post-increment adds size bytes to address register
// - direction zero reads memory into first register
// - direction one stores first register to memory
// - bits 18:17, 15:14, 13:0 read zero
// - autoexec write while busy sets busy error
// - autoexec bit 1: second register access reruns
// - autoexec bit 0: first register access reruns
// - autoexec at dmi address, bits 31:2 zero
// - type 0 register, 2 memory, else error two
// - nonzero error blocks command writes and starts
// - second register address, first register data
package dbg_abs_pkg;
  // debug module interface word addresses
  localparam logic [6:0] ADDR_FIRST_DATA = 7'h04;
  localparam logic [6:0] ADDR_SECOND_DATA = 7'h05;
  localparam logic [6:0] ADDR_ABS_STATUS = 7'h16;
  localparam logic [6:0] ADDR_COMMAND = 7'h17;
  localparam logic [6:0] ADDR_AUTOEXEC = 7'h18;
  // command word fields
  localparam int TYPE_HI = 31;
  localparam int TYPE_LO = 24;
  localparam int VIRT_BIT = 23;
  localparam int SIZE_HI = 22;
  localparam int SIZE_LO = 20;
  localparam int POSTINC_BIT = 19;
  localparam int POSTEXEC_BIT = 18;
  localparam int TRANSFER_BIT = 17;
  localparam int WRITE_BIT = 16;
  localparam int REGNO_HI = 15;
  localparam int REGNO_LO = 0;
  localparam logic [7:0] TYPE_REG = 8'h00;
  localparam logic [7:0] TYPE_MEM = 8'h02;
  localparam logic [2:0] SIZE_32 = 3'h2;
  localparam logic [31:0] COMMAND_RESET = 32'h00220000;
  // readable command bits: size and post-increment only
  localparam logic [31:0] COMMAND_READ_MASK = 32'h00780000;
  localparam logic [15:0] REGNO_CSR_LAST = 16'h0FFF;
  localparam logic [15:0] REGNO_GPR_LAST = 16'h101F;
  // status register fields
  localparam int ERR_HI = 10;
  localparam int ERR_LO = 8;
  localparam int BUSY_BIT = 12;
  localparam logic [3:0] DATA_COUNT = 4'h2;
  localparam int COUNT_HI = 3;
  localparam int COUNT_LO = 0;
  // command error codes
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_BUSY = 3'h1;
  localparam logic [2:0] ERR_NOT_SUPPORTED = 3'h2;
  localparam logic [2:0] ERR_EXCEPTION = 3'h3;
  // autoexec bits
  localparam int AUTO_FIRST_BIT = 0;
  localparam int AUTO_SECOND_BIT = 1;
  localparam logic [1:0] AUTO_RESET = 2'h0;
  // memory regions that only take 32-bit access
  localparam logic [31:0] ITCM_BASE = 32'hEE000000;
  localparam logic [31:0] ITCM_MASK = 32'hFF000000;
  localparam logic [31:0] PIC_BASE = 32'hF00C0000;
  localparam logic [31:0] PIC_MASK = 32'hFFFF0000;

  typedef struct packed {
    logic [6:0] addr;
    logic write;
    logic [31:0] wdata;
  } dmi_req_t;

  typedef struct packed {
    logic is_mem;
    logic write;
    logic [2:0] size;
    logic [15:0] regno;
    logic [31:0] addr;
    logic [31:0] wdata;
  } exec_cmd_t;
endpackage

// >>> rtl/debug_abstract_mem_cmd.sv
// abstract command decode, launch, autoexec and data registers
`timescale 1ns/1ps
module debug_abstract_mem_cmd (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dmi_req_valid,
  input wire dbg_abs_pkg::dmi_req_t dmi_req,
  output logic dmi_resp_valid,
  output logic [31:0] dmi_resp_rdata,
  output logic exec_valid,
  output dbg_abs_pkg::exec_cmd_t exec_cmd,
  input wire logic exec_done,
  input wire logic [2:0] exec_err,
  input wire logic [31:0] exec_rdata,
  output logic busy,
  output logic [2:0] cmd_err
);
  typedef enum logic {ST_IDLE, ST_EXEC} state_t;

  state_t state_reg, state_next;
  logic busy_reg, busy_next;
  logic [31:0] command_reg, command_next;
  logic [1:0] auto_reg, auto_next;
  logic [31:0] first_data_reg, first_data_next;
  logic [31:0] second_data_reg, second_data_next;
  logic [2:0] err_reg, err_next;
  logic resp_valid_reg, resp_valid_next;
  logic [31:0] resp_rdata_reg, resp_rdata_next;
  logic exec_valid_reg, exec_valid_next;
  dbg_abs_pkg::exec_cmd_t exec_cmd_reg, exec_cmd_next;

  // address lies where only word access is allowed
  function automatic logic word_only_region(input logic [31:0] addr);
    word_only_region = ((addr & dbg_abs_pkg::ITCM_MASK) == dbg_abs_pkg::ITCM_BASE) ||
                       ((addr & dbg_abs_pkg::PIC_MASK) == dbg_abs_pkg::PIC_BASE);
  endfunction

  // error code a command earns before it is launched
  function automatic logic [2:0] check_cmd(input logic [31:0] cmd, input logic [31:0] addr);
    logic [7:0] ctype;
    logic [2:0] size;
    ctype = cmd[dbg_abs_pkg::TYPE_HI:dbg_abs_pkg::TYPE_LO];
    size = cmd[dbg_abs_pkg::SIZE_HI:dbg_abs_pkg::SIZE_LO];
    check_cmd = dbg_abs_pkg::ERR_NONE;
    if (ctype == dbg_abs_pkg::TYPE_REG) begin
      if (cmd[dbg_abs_pkg::TRANSFER_BIT]) begin
        if (size != dbg_abs_pkg::SIZE_32 || cmd[dbg_abs_pkg::POSTEXEC_BIT]) begin
          check_cmd = dbg_abs_pkg::ERR_NOT_SUPPORTED;
        end else if (cmd[dbg_abs_pkg::REGNO_HI:dbg_abs_pkg::REGNO_LO] > dbg_abs_pkg::REGNO_GPR_LAST) begin
          check_cmd = dbg_abs_pkg::ERR_EXCEPTION;
        end
      end
    end else if (ctype == dbg_abs_pkg::TYPE_MEM) begin
      if (size > dbg_abs_pkg::SIZE_32) begin
        check_cmd = dbg_abs_pkg::ERR_NOT_SUPPORTED;
      end else if (size < dbg_abs_pkg::SIZE_32 && word_only_region(addr)) begin
        check_cmd = dbg_abs_pkg::ERR_EXCEPTION;
      end
    end else begin
      check_cmd = dbg_abs_pkg::ERR_NOT_SUPPORTED;
    end
  endfunction

  // byte count of a legal size code
  function automatic logic [31:0] size_bytes(input logic [2:0] size);
    size_bytes = 32'h00000001 << size;
  endfunction

  logic is_first;
  logic is_second;
  logic is_cmd;
  logic is_auto;
  logic is_status;
  logic wr_req;
  logic idle_now;
  logic done_now;
  logic done_ok;
  logic cmd_launch;
  logic auto_launch;
  logic launch;
  logic launch_run;
  logic [31:0] launch_cmd;
  logic [2:0] launch_err;

  // request decode; the debugger bus runs on this clock, so no synchroniser
  always_comb begin
    is_first = dmi_req_valid && dmi_req.addr == dbg_abs_pkg::ADDR_FIRST_DATA;
    is_second = dmi_req_valid && dmi_req.addr == dbg_abs_pkg::ADDR_SECOND_DATA;
    is_cmd = dmi_req_valid && dmi_req.addr == dbg_abs_pkg::ADDR_COMMAND;
    is_auto = dmi_req_valid && dmi_req.addr == dbg_abs_pkg::ADDR_AUTOEXEC;
    is_status = dmi_req_valid && dmi_req.addr == dbg_abs_pkg::ADDR_ABS_STATUS;
    wr_req = dmi_req_valid && dmi_req.write;
    idle_now = state_reg == ST_IDLE;
    done_now = state_reg == ST_EXEC && exec_done;
    done_ok = done_now && exec_err == dbg_abs_pkg::ERR_NONE;
    // a set error field blocks both kinds of start
    cmd_launch = idle_now && is_cmd && wr_req && err_reg == dbg_abs_pkg::ERR_NONE;
    auto_launch = idle_now && err_reg == dbg_abs_pkg::ERR_NONE &&
                  ((is_first && auto_reg[dbg_abs_pkg::AUTO_FIRST_BIT]) ||
                   (is_second && auto_reg[dbg_abs_pkg::AUTO_SECOND_BIT]));
  end

  // every start, written or automatic, passes the same checks
  always_comb begin
    launch = cmd_launch || auto_launch;
    launch_cmd = command_next;
    launch_err = dbg_abs_pkg::ERR_NONE;
    launch_run = 1'b0;
    if (launch) begin
      launch_err = check_cmd(launch_cmd, second_data_next);
      // register access without transfer succeeds with nothing to run
      launch_run = launch_err == dbg_abs_pkg::ERR_NONE &&
                   (launch_cmd[dbg_abs_pkg::TYPE_HI:dbg_abs_pkg::TYPE_LO] == dbg_abs_pkg::TYPE_MEM ||
                    launch_cmd[dbg_abs_pkg::TRANSFER_BIT]);
    end
  end

  // data registers: debugger writes only when idle, results only on success
  always_comb begin
    first_data_next = first_data_reg;
    second_data_next = second_data_reg;
    if (done_ok) begin
      if (!exec_cmd_reg.write) begin
        first_data_next = exec_rdata;
      end
      if (command_reg[dbg_abs_pkg::POSTINC_BIT] && exec_cmd_reg.is_mem) begin
        second_data_next = second_data_reg + size_bytes(exec_cmd_reg.size);
      end
    end
    // writes while busy are dropped so a running command sees stable operands
    if (idle_now && wr_req && is_first) begin
      first_data_next = dmi_req.wdata;
    end
    if (idle_now && wr_req && is_second) begin
      second_data_next = dmi_req.wdata;
    end
  end

  // data register flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_data_reg <= 32'h00000000;
      second_data_reg <= 32'h00000000;
    end else begin
      first_data_reg <= first_data_next;
      second_data_reg <= second_data_next;
    end
  end

  // command word and autoexec control
  always_comb begin
    command_next = command_reg;
    auto_next = auto_reg;
    if (done_ok && command_reg[dbg_abs_pkg::POSTINC_BIT] && !exec_cmd_reg.is_mem) begin
      // register number wraps at the top of its field
      command_next[dbg_abs_pkg::REGNO_HI:dbg_abs_pkg::REGNO_LO] =
        command_reg[dbg_abs_pkg::REGNO_HI:dbg_abs_pkg::REGNO_LO] + 16'h0001;
    end
    if (cmd_launch) begin
      command_next = dmi_req.wdata;
      command_next[dbg_abs_pkg::VIRT_BIT] = 1'b0;
    end
    if (idle_now && wr_req && is_auto) begin
      auto_next = dmi_req.wdata[dbg_abs_pkg::AUTO_SECOND_BIT:dbg_abs_pkg::AUTO_FIRST_BIT];
    end
  end

  // command and autoexec flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      command_reg <= dbg_abs_pkg::COMMAND_RESET;
      auto_reg <= dbg_abs_pkg::AUTO_RESET;
    end else begin
      command_reg <= command_next;
      auto_reg <= auto_next;
    end
  end

  // error field: hardware sets win over a clear in the same cycle
  always_comb begin
    err_next = err_reg;
    if (done_now && exec_err != dbg_abs_pkg::ERR_NONE) begin
      err_next = exec_err;
    end
    if (!idle_now) begin
      if ((is_first || is_second || (is_cmd && wr_req) || (is_auto && wr_req)) &&
          err_next == dbg_abs_pkg::ERR_NONE) begin
        err_next = dbg_abs_pkg::ERR_BUSY;
      end
    end else if (is_status && wr_req) begin
      err_next = err_reg & ~dmi_req.wdata[dbg_abs_pkg::ERR_HI:dbg_abs_pkg::ERR_LO];
    end
    if (launch_err != dbg_abs_pkg::ERR_NONE) begin
      err_next = launch_err;
    end
  end

  // error flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= dbg_abs_pkg::ERR_NONE;
    end else begin
      err_reg <= err_next;
    end
  end

  // launch and completion of the core-side command
  always_comb begin
    state_next = state_reg;
    busy_next = busy_reg;
    exec_valid_next = exec_valid_reg;
    exec_cmd_next = exec_cmd_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (launch_run) begin
          state_next = ST_EXEC;
          busy_next = 1'b1;
          exec_valid_next = 1'b1;
          exec_cmd_next.is_mem = launch_cmd[dbg_abs_pkg::TYPE_HI:dbg_abs_pkg::TYPE_LO] == dbg_abs_pkg::TYPE_MEM;
          exec_cmd_next.write = launch_cmd[dbg_abs_pkg::WRITE_BIT];
          exec_cmd_next.size = launch_cmd[dbg_abs_pkg::SIZE_HI:dbg_abs_pkg::SIZE_LO];
          exec_cmd_next.regno = launch_cmd[dbg_abs_pkg::REGNO_HI:dbg_abs_pkg::REGNO_LO];
          exec_cmd_next.addr = second_data_next;
          exec_cmd_next.wdata = first_data_next;
        end
      end
      ST_EXEC: begin
        // command held stable until the core reports done
        if (exec_done) begin
          state_next = ST_IDLE;
          busy_next = 1'b0;
          exec_valid_next = 1'b0;
        end
      end
    endcase
  end

  // execution flops; busy has its own flop so the pin comes from a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      exec_valid_reg <= 1'b0;
      exec_cmd_reg <= '0;
    end else begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      exec_valid_reg <= exec_valid_next;
      exec_cmd_reg <= exec_cmd_next;
    end
  end

  // register reads answer one cycle after the request
  always_comb begin
    resp_valid_next = dmi_req_valid;
    resp_rdata_next = resp_rdata_reg;
    if (dmi_req_valid) begin
      resp_rdata_next = 32'h00000000;
      if (is_first) begin
        resp_rdata_next = first_data_reg;
      end else if (is_second) begin
        resp_rdata_next = second_data_reg;
      end else if (is_cmd) begin
        resp_rdata_next = command_reg & dbg_abs_pkg::COMMAND_READ_MASK;
      end else if (is_auto) begin
        resp_rdata_next[dbg_abs_pkg::AUTO_SECOND_BIT:dbg_abs_pkg::AUTO_FIRST_BIT] = auto_reg;
      end else if (is_status) begin
        resp_rdata_next[dbg_abs_pkg::BUSY_BIT] = busy_reg;
        resp_rdata_next[dbg_abs_pkg::ERR_HI:dbg_abs_pkg::ERR_LO] = err_reg;
        resp_rdata_next[dbg_abs_pkg::COUNT_HI:dbg_abs_pkg::COUNT_LO] = dbg_abs_pkg::DATA_COUNT;
      end
    end
  end

  // response flops; read data stands until the next answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_reg <= 1'b0;
      resp_rdata_reg <= 32'h00000000;
    end else begin
      resp_valid_reg <= resp_valid_next;
      resp_rdata_reg <= resp_rdata_next;
    end
  end

  assign dmi_resp_valid = resp_valid_reg;
  assign dmi_resp_rdata = resp_rdata_reg;
  assign exec_valid = exec_valid_reg;
  assign exec_cmd = exec_cmd_reg;
  assign busy = busy_reg;
  assign cmd_err = err_reg;
endmodule

// >>> sim/debug_abstract_mem_cmd_sva.sv
// assertion checker for the abstract command block
`timescale 1ns/1ps
module debug_abstract_mem_cmd_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dmi_req_valid,
  input wire dbg_abs_pkg::dmi_req_t dmi_req,
  input wire logic dmi_resp_valid,
  input wire logic [31:0] dmi_resp_rdata,
  input wire logic exec_valid,
  input wire dbg_abs_pkg::exec_cmd_t exec_cmd,
  input wire logic exec_done,
  input wire logic [2:0] exec_err,
  input wire logic [31:0] exec_rdata,
  input wire logic busy,
  input wire logic [2:0] cmd_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // decoded debugger requests; go means the command write is not refused
  logic cmd_wr, go, rd_cmd, rd_auto, wr_auto, small_only;
  logic [31:0] w;
  assign w = dmi_req.wdata;
  assign cmd_wr = dmi_req_valid && dmi_req.write && dmi_req.addr == dbg_abs_pkg::ADDR_COMMAND;
  assign go = cmd_wr && !busy && cmd_err == 3'h0;
  assign rd_cmd = dmi_req_valid && !dmi_req.write && dmi_req.addr == dbg_abs_pkg::ADDR_COMMAND;
  assign rd_auto = dmi_req_valid && !dmi_req.write && dmi_req.addr == dbg_abs_pkg::ADDR_AUTOEXEC;
  assign wr_auto = dmi_req_valid && dmi_req.write && dmi_req.addr == dbg_abs_pkg::ADDR_AUTOEXEC;
  // word-only regions refuse byte and halfword access
  assign small_only = (exec_cmd.addr & dbg_abs_pkg::ITCM_MASK) == dbg_abs_pkg::ITCM_BASE
    || (exec_cmd.addr & dbg_abs_pkg::PIC_MASK) == dbg_abs_pkg::PIC_BASE;
  property p_resp; dmi_req_valid |=> dmi_resp_valid; endproperty
  a_resp: assert property (p_resp) else $error("missing response");
  property p_type; go && w[31:24] != 8'h00 && w[31:24] != 8'h02 |=> cmd_err == 3'h2 && !exec_valid; endproperty
  a_type: assert property (p_type) else $error("bad type not refused");
  property p_size; go && w[31:24] == 8'h02 && w[22:20] > 3'h2 |=> cmd_err == 3'h2 && !exec_valid; endproperty
  a_size: assert property (p_size) else $error("bad size not refused");
  property p_regno; go && w[31:17] == 15'h0011 && w[15:0] > 16'h101F |=> cmd_err == 3'h3; endproperty
  a_regno: assert property (p_regno) else $error("bad register not refused");
  property p_gpr; go && w[31:17] == 15'h0011 && w[15:0] <= 16'h101F |=> exec_valid && exec_cmd.regno == $past(w[15:0]);
  endproperty
  a_gpr: assert property (p_gpr) else $error("legal register not run");
  property p_block; cmd_wr && cmd_err != 3'h0 && !busy |=> !exec_valid && cmd_err == $past(cmd_err); endproperty
  a_block: assert property (p_block) else $error("command ran with error set");
  property p_busy; wr_auto && busy && !exec_done && cmd_err == 3'h0 |=> cmd_err == 3'h1; endproperty
  a_busy: assert property (p_busy) else $error("busy error missing");
  property p_rcmd; rd_cmd |=> (dmi_resp_rdata & ~dbg_abs_pkg::COMMAND_READ_MASK) == 32'h00000000; endproperty
  a_rcmd: assert property (p_rcmd) else $error("command reads nonzero reserved bits");
  property p_rauto; rd_auto |=> dmi_resp_rdata[31:2] == 30'h00000000; endproperty
  a_rauto: assert property (p_rauto) else $error("autoexec reads nonzero upper bits");
  property p_exsz; exec_valid && exec_cmd.is_mem |-> exec_cmd.size <= 3'h2 && !(exec_cmd.size < 3'h2 && small_only);
  endproperty
  a_exsz: assert property (p_exsz) else $error("illegal size launched");
  property p_drop; exec_valid && exec_done |=> !exec_valid && !busy; endproperty
  a_drop: assert property (p_drop) else $error("command held after done");
endmodule
bind debug_abstract_mem_cmd debug_abstract_mem_cmd_chk debug_abstract_mem_cmd_chk_i (.clk(clk), .rst_n(rst_n),
  .dmi_req_valid(dmi_req_valid), .dmi_req(dmi_req), .dmi_resp_valid(dmi_resp_valid), .dmi_resp_rdata(dmi_resp_rdata),
  .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_done(exec_done), .exec_err(exec_err),
  .exec_rdata(exec_rdata), .busy(busy), .cmd_err(cmd_err));

// >>> sim/core_exec_model.sv
// behavioural core side answering launched commands
`timescale 1ns/1ps
module core_exec_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic exec_valid,
  input wire dbg_abs_pkg::exec_cmd_t exec_cmd,
  output logic exec_done,
  output logic [2:0] exec_err,
  output logic [31:0] exec_rdata,
  output logic [31:0] last_waddr,
  output logic [31:0] last_wdata
);
  logic [3:0] cnt;
  // address bit 2 picks a slow answer; read data churns between answers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_done <= 1'b0;
      exec_err <= 3'h0;
      exec_rdata <= 32'h00000000;
      cnt <= 4'h0;
    end else begin
      exec_done <= 1'b0;
      exec_err <= 3'h0;
      exec_rdata <= ~exec_rdata;
      if (!exec_valid) begin
        cnt <= 4'h0;
      end else if (!exec_done) begin
        cnt <= cnt + 4'h1;
        if (cnt == (exec_cmd.addr[2] ? 4'h5 : 4'h0)) begin
          exec_done <= 1'b1;
          // top nibble C stands for an unmapped address that answers with a bus error
          exec_err <= (exec_cmd.addr[31:28] == 4'hC) ? 3'h5 : 3'h0;
          cnt <= 4'h0;
          exec_rdata <= exec_cmd.addr ^ 32'h5A5A5A5A;
        end
      end
    end
  end
  // store side: capture address and data of the last write
  always_ff @(posedge clk) begin
    if (exec_valid && exec_cmd.write) begin
      last_waddr <= exec_cmd.addr;
      last_wdata <= exec_cmd.wdata;
    end
  end
endmodule

// >>> sim/debug_abstract_mem_cmd_bench.sv
// self-checking bench for the abstract command block
`timescale 1ns/1ps
module debug_abstract_mem_cmd_bench;
  logic clk, rst_n, dmi_req_valid, dmi_resp_valid, exec_valid, exec_done, busy;
  logic [31:0] dmi_resp_rdata, exec_rdata, last_waddr, last_wdata;
  logic [2:0] cmd_err, exec_err;
  dbg_abs_pkg::dmi_req_t dmi_req;
  dbg_abs_pkg::exec_cmd_t exec_cmd;
  int errors, compares;
  logic [15:0] regs [5] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h101F, 16'h1020};
  debug_abstract_mem_cmd debug_abstract_mem_cmd_i (.clk(clk), .rst_n(rst_n), .dmi_req_valid(dmi_req_valid),
    .dmi_req(dmi_req), .dmi_resp_valid(dmi_resp_valid), .dmi_resp_rdata(dmi_resp_rdata), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .exec_done(exec_done), .exec_err(exec_err), .exec_rdata(exec_rdata), .busy(busy),
    .cmd_err(cmd_err));
  core_exec_model core_exec_model_i (.clk(clk), .rst_n(rst_n), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
    .exec_done(exec_done), .exec_err(exec_err), .exec_rdata(exec_rdata), .last_waddr(last_waddr),
    .last_wdata(last_wdata));
  always #5 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one debugger access; the answer stands in the cycle after the request
  task automatic dmi(input logic [6:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    #1;
    dmi_req_valid = 1'b1;
    dmi_req = '{addr: a, write: w, wdata: d};
    @(posedge clk);
    #1;
    dmi_req_valid = 1'b0;
    r = dmi_resp_rdata;
    check({31'h0, dmi_resp_valid}, 32'h00000001);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] r;
    dmi(a, 1'b1, d, r);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [31:0] e);
    logic [31:0] r;
    dmi(a, 1'b0, 32'h00000000, r);
    check(r, e);
  endtask
  // bounded wait for the running command to finish
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, busy}, 32'h00000000);
  endtask
  // compare the error field, then clear it
  task automatic err(input logic [2:0] e);
    check({29'h0, cmd_err}, {29'h0, e});
    wr(dbg_abs_pkg::ADDR_ABS_STATUS, 32'h00000700);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog far beyond the 150 or so cycles the tests need
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    dmi_req_valid = 1'b0;
    dmi_req = '0;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rdc(dbg_abs_pkg::ADDR_COMMAND, 32'h00200000);
    rdc(dbg_abs_pkg::ADDR_AUTOEXEC, 32'h00000000);
    wr(dbg_abs_pkg::ADDR_SECOND_DATA, 32'h10000000);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02A8FFFF);
    idle();
    err(3'h0);
    rdc(dbg_abs_pkg::ADDR_FIRST_DATA, 32'h4A5A5A5A);
    rdc(dbg_abs_pkg::ADDR_SECOND_DATA, 32'h10000004);
    rdc(dbg_abs_pkg::ADDR_COMMAND, 32'h00280000);
    wr(dbg_abs_pkg::ADDR_FIRST_DATA, 32'hCAFE1234);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02190000);
    idle();
    check(last_wdata, 32'hCAFE1234);
    check(last_waddr, 32'h10000004);
    rdc(dbg_abs_pkg::ADDR_SECOND_DATA, 32'h10000006);
    wr(dbg_abs_pkg::ADDR_SECOND_DATA, 32'hEE000010);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02000000);
    err(3'h3);
    wr(dbg_abs_pkg::ADDR_SECOND_DATA, 32'hF00C0000);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02100000);
    err(3'h3);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02300000);
    err(3'h2);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h01220000);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02200000);
    check({31'h0, exec_valid}, 32'h00000000);
    err(3'h2);
    for (int i = 0; i < 5; i++) begin
      wr(dbg_abs_pkg::ADDR_COMMAND, {16'h0022, regs[i]});
      idle();
      err(regs[i] > 16'h101F ? 3'h3 : 3'h0);
    end
    wr(dbg_abs_pkg::ADDR_SECOND_DATA, 32'h20000000);
    wr(dbg_abs_pkg::ADDR_AUTOEXEC, 32'h00000001);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02280000);
    idle();
    rdc(dbg_abs_pkg::ADDR_FIRST_DATA, 32'h7A5A5A5A);
    idle();
    rdc(dbg_abs_pkg::ADDR_SECOND_DATA, 32'h20000008);
    wr(dbg_abs_pkg::ADDR_AUTOEXEC, 32'hFFFFFFFE);
    rdc(dbg_abs_pkg::ADDR_AUTOEXEC, 32'h00000002);
    rdc(dbg_abs_pkg::ADDR_SECOND_DATA, 32'h20000008);
    idle();
    err(3'h0);
    wr(dbg_abs_pkg::ADDR_AUTOEXEC, 32'h00000000);
    rdc(dbg_abs_pkg::ADDR_SECOND_DATA, 32'h2000000C);
    wr(dbg_abs_pkg::ADDR_SECOND_DATA, 32'h30000004);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02200000);
    wr(dbg_abs_pkg::ADDR_AUTOEXEC, 32'h00000003);
    idle();
    err(3'h1);
    rdc(dbg_abs_pkg::ADDR_AUTOEXEC, 32'h00000000);
    wr(dbg_abs_pkg::ADDR_SECOND_DATA, 32'hC0000000);
    wr(dbg_abs_pkg::ADDR_COMMAND, 32'h02280000);
    idle();
    err(3'h5);
    rdc(dbg_abs_pkg::ADDR_SECOND_DATA, 32'hC0000000);
    tally_and_finish();
  end
endmodule
